// ==== hw/occ_defines.vh ====
// Behaviour
// - three channels: two supplies, one contact
// - warm-up: on set seconds before measurement
// - zero warm-up time keeps channel off
// - warm-up channels with nonzero warm-up time on during burst transmission
// - digital level is setpoint XOR invert
// - frequency equals setpoint times factor, max 1000
// - pulses per minute setpoint times factor, max 320
// - frequency and pulse only on contact
// - reserved mode only on low supply
// - voltage selection only on sensor supply
// - hold unit string of 0-8 characters
// - filter window ends at measurement instant
// - gated setpoint withheld from next measurement
// - gate release is OR of selected triggers
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH

// ==========================================================
// timing
`define OCC_CLK_HZ 250000000
`define OCC_CLK_PERIOD_PS 4000
`define OCC_MS_PS 1000000000
`define OCC_MS_TICKS (`OCC_MS_PS / `OCC_CLK_PERIOD_PS)
`define OCC_MS_PER_S 1000
`define OCC_S_PER_MIN 60

// ==========================================================
// ceilings
`define OCC_FREQ_MAX_HZ 32'h000003E8
`define OCC_PULSE_MAX_PM 32'h00000140

// ==========================================================
// channel modes
`define OCC_MODE_OFF 3'h0
`define OCC_MODE_WARM 3'h1
`define OCC_MODE_DIG 3'h2
`define OCC_MODE_RSVD 3'h3
`define OCC_MODE_FREQ 3'h4
`define OCC_MODE_PULSE 3'h5

// ==========================================================
// register byte offsets
`define OCC_REG_CYCLE 6'h00
`define OCC_REG_WARM 6'h04
`define OCC_REG_FILT 6'h08
`define OCC_REG_CH0 6'h0C
`define OCC_REG_CH1 6'h10
`define OCC_REG_CH2 6'h14
`define OCC_REG_RATE 6'h18
`define OCC_REG_ULEN 6'h1C
`define OCC_REG_ULO 6'h20
`define OCC_REG_UHI 6'h24
`define OCC_REG_SEL0 6'h28
`define OCC_REG_SEL1 6'h2C
`define OCC_REG_SEL2 6'h30
`define OCC_REG_STAT 6'h34
`define OCC_REG_REMAIN 6'h38

// ==========================================================
// channel config field positions
`define OCC_F_MODE_LSB 0
`define OCC_F_INV 4
`define OCC_F_SETP 5
`define OCC_F_VSEL_LSB 8
`define OCC_UNIT_MAX 4'h8

// ==========================================================
// reset values
`define OCC_RST_CYCLE 16'h003C
`define OCC_RST_WARM 16'h0000
`define OCC_RST_FILT 16'h0000
`define OCC_RST_FACTOR 16'h0001

`endif

// ==== hw/occ_timebase.v ====
`timescale 1ns/1ps
`include "occ_defines.vh"
module occ_timebase #(
    parameter MS_TICKS = `OCC_MS_TICKS
) (
    // clock and reset
    input wire clock,
    input wire srst,
    // settings, already in ms
    input wire [31:0] cycle_ms,
    input wire [31:0] warm_ms,
    input wire [15:0] filt_ms,
    // timing state
    output reg meas_r,
    output reg warm_r,
    output reg filt_r,
    output reg [31:0] remain_r
);
    reg [31:0] tick_r;
    wire ms_tick = (tick_r == MS_TICKS - 1);

    always @(posedge clock) begin
        if (srst) begin
            tick_r <= 32'h0;
            remain_r <= 32'h0;
            meas_r <= 1'b0;
            warm_r <= 1'b0;
            filt_r <= 1'b0;
        end else begin
            tick_r <= ms_tick ? 32'h0 : tick_r + 32'h1;
            meas_r <= 1'b0;
            if (ms_tick) begin
                if (cycle_ms == 32'h0) begin
                    remain_r <= 32'h0;
                end else if (remain_r == 32'h0) begin
                    remain_r <= cycle_ms;
                end else if (remain_r == 32'h1) begin
                    meas_r <= 1'b1;
                    remain_r <= cycle_ms;
                end else begin
                    remain_r <= remain_r - 32'h1;
                end
            end
            // on until the instant, off after it; zero time never
            warm_r <= (warm_ms != 32'h0) && (remain_r != 32'h0) && (remain_r <= warm_ms);
            // window closes at the instant itself
            filt_r <= (filt_ms != 16'h0) && (remain_r != 32'h0) && (remain_r <= {16'h0, filt_ms});
        end
    end
endmodule

// ==== hw/occ_rate_gen.v ====
`timescale 1ns/1ps
`include "occ_defines.vh"
module occ_rate_gen #(
    parameter CLK_HZ = `OCC_CLK_HZ
) (
    // clock and reset
    input wire clock,
    input wire srst,
    // rate request
    input wire [31:0] rate,
    input wire per_minute,
    // square wave
    output reg wave_r
);
    // phase accumulator: no divider, jitter one clock, phases equal on average
    localparam [39:0] HALF_S = CLK_HZ / 2;
    // product taken at 40 bits: half the clock rate times sixty overflows 32
    localparam [39:0] HALF_MIN = HALF_S * `OCC_S_PER_MIN;
    reg [39:0] acc_r;
    wire [39:0] thr = per_minute ? HALF_MIN : HALF_S;
    wire [39:0] sum = acc_r + {8'h00, rate};

    always @(posedge clock) begin
        if (srst || rate == 32'h0) begin
            acc_r <= 40'h0;
            wave_r <= 1'b0;
        end else if (sum >= thr) begin
            acc_r <= sum - thr;
            wave_r <= ~wave_r;
        end else begin
            acc_r <= sum;
        end
    end
endmodule

// ==== hw/occ_top.v ====
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "occ_defines.vh"
module occ_top #(
    parameter NTRIG = 8,
    parameter CLK_HZ = `OCC_CLK_HZ,
    parameter MS_TICKS = `OCC_MS_TICKS
) (
    // clock and reset
    input wire clock,
    input wire srst,
    // avalon-mm slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // system events
    input wire [NTRIG-1:0] trig_active,
    input wire burst_active,
    // output channels
    output reg switched_sensor_supply,
    output reg [1:0] sensor_supply_vsel,
    output reg switched_low_voltage_supply,
    output reg contact,
    // measurement timing
    output reg meas_pulse,
    output reg filter_window
);
    // ==========================================================
    // helpers
    function [31:0] occ_merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] be;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                occ_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    function [15:0] occ_merge16;
        input [15:0] old;
        input [15:0] wd;
        input [1:0] be;
        begin
            occ_merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    function [31:0] occ_s_to_ms;
        input [15:0] s;
        begin
            occ_s_to_ms = {16'h0, s} * `OCC_MS_PER_S;
        end
    endfunction

    // modes outside a channel's set fall back to off
    function [2:0] occ_legal_mode;
        input [1:0] ch;
        input [2:0] m;
        begin
            case (m)
                `OCC_MODE_OFF, `OCC_MODE_WARM, `OCC_MODE_DIG: occ_legal_mode = m;
                `OCC_MODE_RSVD: occ_legal_mode = (ch == 2'h1) ? m : `OCC_MODE_OFF;
                `OCC_MODE_FREQ, `OCC_MODE_PULSE: occ_legal_mode = (ch == 2'h2) ? m : `OCC_MODE_OFF;
                default: occ_legal_mode = `OCC_MODE_OFF;
            endcase
        end
    endfunction

    function occ_level;
        input [2:0] m;
        input inv;
        input setp;
        input rel;
        input warm;
        input warm_nz;
        input wave;
        begin
            case (m)
                // burst holds warm-up channels on, but zero time still wins
                `OCC_MODE_WARM: occ_level = warm | (burst_active & warm_nz);
                // withheld setpoint drives low
                `OCC_MODE_DIG: occ_level = rel & (setp ^ inv);
                `OCC_MODE_FREQ, `OCC_MODE_PULSE: occ_level = rel & wave;
                default: occ_level = 1'b0;
            endcase
        end
    endfunction

    function [31:0] occ_sat;
        input [31:0] v;
        input [31:0] ceil;
        begin
            occ_sat = (v > ceil) ? ceil : v;
        end
    endfunction

    // ==========================================================
    // registers
    reg [15:0] cycle_s_r;
    reg [15:0] warm_s_r;
    reg [15:0] filt_ms_r;
    reg [2:0] mode0_r;
    reg [2:0] mode1_r;
    reg [2:0] mode2_r;
    reg [2:0] inv_r;
    reg [2:0] setp_r;
    reg [1:0] vsel_r;
    reg [15:0] rate_setp_r;
    reg [15:0] rate_fac_r;
    reg [3:0] unit_len_r;
    reg [31:0] unit_lo_r;
    reg [31:0] unit_hi_r;
    reg [NTRIG-1:0] sel0_r;
    reg [NTRIG-1:0] sel1_r;
    reg [NTRIG-1:0] sel2_r;
    reg [2:0] release_r;
    reg [31:0] rd_nxt;

    wire meas_w;
    wire warm_w;
    wire filt_w;
    wire [31:0] remain_w;
    wire wave_w;
    wire wr_go = avs_write & ~avs_waitrequest;
    wire [31:0] wd_cfg0 = occ_merge(32'h0, avs_writedata, avs_byteenable);
    // masks merged as full words, then cut back to the trigger count
    wire [31:0] sel0_m = occ_merge({{(32-NTRIG){1'b0}}, sel0_r}, avs_writedata, avs_byteenable);
    wire [31:0] sel1_m = occ_merge({{(32-NTRIG){1'b0}}, sel1_r}, avs_writedata, avs_byteenable);
    wire [31:0] sel2_m = occ_merge({{(32-NTRIG){1'b0}}, sel2_r}, avs_writedata, avs_byteenable);

    // ==========================================================
    // timing and rate
    occ_timebase #(
        .MS_TICKS(MS_TICKS)
    ) u_timebase (
        .clock(clock),
        .srst(srst),
        .cycle_ms(occ_s_to_ms(cycle_s_r)),
        .warm_ms(occ_s_to_ms(warm_s_r)),
        .filt_ms(filt_ms_r),
        .meas_r(meas_w),
        .warm_r(warm_w),
        .filt_r(filt_w),
        .remain_r(remain_w)
    );

    wire [31:0] product = {16'h0, rate_setp_r} * {16'h0, rate_fac_r};
    wire is_pulse = (mode2_r == `OCC_MODE_PULSE);
    wire is_rate = (mode2_r == `OCC_MODE_FREQ) | is_pulse;
    // over-ceiling requests saturate instead of running fast
    wire [31:0] rate_req = !is_rate ? 32'h0 :
        is_pulse ? occ_sat(product, `OCC_PULSE_MAX_PM) : occ_sat(product, `OCC_FREQ_MAX_HZ);

    occ_rate_gen #(
        .CLK_HZ(CLK_HZ)
    ) u_rate (
        .clock(clock),
        .srst(srst),
        .rate(rate_req),
        .per_minute(is_pulse),
        .wave_r(wave_w)
    );

    // ==========================================================
    // register writes
    always @(posedge clock) begin
        if (srst) begin
            cycle_s_r <= `OCC_RST_CYCLE;
            warm_s_r <= `OCC_RST_WARM;
            filt_ms_r <= `OCC_RST_FILT;
            mode0_r <= `OCC_MODE_OFF;
            mode1_r <= `OCC_MODE_OFF;
            mode2_r <= `OCC_MODE_OFF;
            inv_r <= 3'h0;
            setp_r <= 3'h0;
            vsel_r <= 2'h0;
            rate_setp_r <= 16'h0;
            rate_fac_r <= `OCC_RST_FACTOR;
            unit_len_r <= 4'h0;
            unit_lo_r <= 32'h0;
            unit_hi_r <= 32'h0;
            sel0_r <= {NTRIG{1'b0}};
            sel1_r <= {NTRIG{1'b0}};
            sel2_r <= {NTRIG{1'b0}};
        end else if (wr_go) begin
            case (avs_address)
                `OCC_REG_CYCLE: cycle_s_r <= occ_merge16(cycle_s_r, avs_writedata[15:0], avs_byteenable[1:0]);
                `OCC_REG_WARM: warm_s_r <= occ_merge16(warm_s_r, avs_writedata[15:0], avs_byteenable[1:0]);
                `OCC_REG_FILT: filt_ms_r <= occ_merge16(filt_ms_r, avs_writedata[15:0], avs_byteenable[1:0]);
                `OCC_REG_CH0: begin
                    if (avs_byteenable[0]) begin
                        mode0_r <= occ_legal_mode(2'h0, wd_cfg0[2:0]);
                        inv_r[0] <= wd_cfg0[`OCC_F_INV];
                        setp_r[0] <= wd_cfg0[`OCC_F_SETP];
                    end
                    // only this channel keeps a voltage selection
                    if (avs_byteenable[1]) begin
                        vsel_r <= wd_cfg0[`OCC_F_VSEL_LSB +: 2];
                    end
                end
                `OCC_REG_CH1: begin
                    if (avs_byteenable[0]) begin
                        mode1_r <= occ_legal_mode(2'h1, wd_cfg0[2:0]);
                        inv_r[1] <= wd_cfg0[`OCC_F_INV];
                        setp_r[1] <= wd_cfg0[`OCC_F_SETP];
                    end
                end
                `OCC_REG_CH2: begin
                    if (avs_byteenable[0]) begin
                        mode2_r <= occ_legal_mode(2'h2, wd_cfg0[2:0]);
                        inv_r[2] <= wd_cfg0[`OCC_F_INV];
                        setp_r[2] <= wd_cfg0[`OCC_F_SETP];
                    end
                end
                `OCC_REG_RATE: begin
                    rate_setp_r <= occ_merge16(rate_setp_r, avs_writedata[15:0], avs_byteenable[1:0]);
                    rate_fac_r <= occ_merge16(rate_fac_r, avs_writedata[31:16], avs_byteenable[3:2]);
                end
                `OCC_REG_ULEN: begin
                    // lengths beyond eight clamp to eight
                    if (avs_byteenable[0]) begin
                        unit_len_r <= (avs_writedata[7:0] > {4'h0, `OCC_UNIT_MAX}) ? `OCC_UNIT_MAX :
                            avs_writedata[3:0];
                    end
                end
                `OCC_REG_ULO: unit_lo_r <= occ_merge(unit_lo_r, avs_writedata, avs_byteenable);
                `OCC_REG_UHI: unit_hi_r <= occ_merge(unit_hi_r, avs_writedata, avs_byteenable);
                `OCC_REG_SEL0: sel0_r <= sel0_m[NTRIG-1:0];
                `OCC_REG_SEL1: sel1_r <= sel1_m[NTRIG-1:0];
                `OCC_REG_SEL2: sel2_r <= sel2_m[NTRIG-1:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // gating, sampled at each measurement instant
    always @(posedge clock) begin
        if (srst) begin
            release_r <= 3'h7;
        end else if (meas_w) begin
            // no selection means ungated; any selected trigger releases
            release_r[0] <= (sel0_r == {NTRIG{1'b0}}) | (|(sel0_r & trig_active));
            release_r[1] <= (sel1_r == {NTRIG{1'b0}}) | (|(sel1_r & trig_active));
            release_r[2] <= (sel2_r == {NTRIG{1'b0}}) | (|(sel2_r & trig_active));
        end
    end

    // ==========================================================
    // channel outputs
    wire warm_nz = (warm_s_r != 16'h0);

    always @(posedge clock) begin
        if (srst) begin
            switched_sensor_supply <= 1'b0;
            switched_low_voltage_supply <= 1'b0;
            contact <= 1'b0;
            sensor_supply_vsel <= 2'h0;
            meas_pulse <= 1'b0;
            filter_window <= 1'b0;
        end else begin
            // three independently configured channels
            switched_sensor_supply <= occ_level(mode0_r, inv_r[0], setp_r[0], release_r[0], warm_w, warm_nz, 1'b0);
            switched_low_voltage_supply <= occ_level(mode1_r, inv_r[1], setp_r[1], release_r[1], warm_w, warm_nz,
                1'b0);
            contact <= occ_level(mode2_r, inv_r[2], setp_r[2], release_r[2], warm_w, warm_nz, wave_w);
            sensor_supply_vsel <= vsel_r;
            meas_pulse <= meas_w;
            filter_window <= filt_w;
        end
    end

    // ==========================================================
    // avalon read path: one wait state, unmapped reads zero
    always @* begin
        rd_nxt = 32'h0;
        case (avs_address)
            `OCC_REG_CYCLE: rd_nxt = {16'h0, cycle_s_r};
            `OCC_REG_WARM: rd_nxt = {16'h0, warm_s_r};
            `OCC_REG_FILT: rd_nxt = {16'h0, filt_ms_r};
            `OCC_REG_CH0: rd_nxt = {22'h0, vsel_r, 2'h0, setp_r[0], inv_r[0], 1'b0, mode0_r};
            `OCC_REG_CH1: rd_nxt = {26'h0, setp_r[1], inv_r[1], 1'b0, mode1_r};
            `OCC_REG_CH2: rd_nxt = {26'h0, setp_r[2], inv_r[2], 1'b0, mode2_r};
            `OCC_REG_RATE: rd_nxt = {rate_fac_r, rate_setp_r};
            `OCC_REG_ULEN: rd_nxt = {28'h0, unit_len_r};
            `OCC_REG_ULO: rd_nxt = unit_lo_r;
            `OCC_REG_UHI: rd_nxt = unit_hi_r;
            `OCC_REG_SEL0: rd_nxt = {{(32-NTRIG){1'b0}}, sel0_r};
            `OCC_REG_SEL1: rd_nxt = {{(32-NTRIG){1'b0}}, sel1_r};
            `OCC_REG_SEL2: rd_nxt = {{(32-NTRIG){1'b0}}, sel2_r};
            `OCC_REG_STAT: rd_nxt = {24'h0, filter_window, warm_w, release_r, contact,
                switched_low_voltage_supply, switched_sensor_supply};
            `OCC_REG_REMAIN: rd_nxt = remain_w;
            default: rd_nxt = 32'h0;
        endcase
    end

    always @(posedge clock) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_nxt;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end
endmodule

// ==== hw/occ_notes_unused.v ====
`timescale 1ns/1ps

// ==== bench/occ_top_sva.sv ====
`timescale 1ns/1ps
module occ_top_sva (
    // clock and reset
    input wire clock,
    input wire srst,
    // avalon-mm slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // channel and timing outputs
    input wire [1:0] sensor_supply_vsel,
    input wire meas_pulse,
    input wire filter_window
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // ==========================================================
    // register bus
    a_wait_next_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not answer in the next cycle");
    a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait_high: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_readdata_stand: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data moved between requests");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 6'h38 |-> avs_readdata == 32'h0)
        else $error("unmapped read returned nonzero data");

    // ==========================================================
    // voltage selection
    a_vsel_follow: assert property (avs_write && !avs_waitrequest && avs_address == 6'h0C && avs_byteenable[1]
        |-> ##2 sensor_supply_vsel == $past(avs_writedata[9:8], 2))
        else $error("voltage selection did not follow the write");
    a_vsel_hold: assert property ((avs_address != 6'h0C || !avs_write) [*3] |=> $stable(sensor_supply_vsel))
        else $error("voltage selection moved without a write");

    // ==========================================================
    // measurement timing
    a_meas_single: assert property (meas_pulse |=> !meas_pulse)
        else $error("measurement pulse longer than one cycle");
    a_filter_end: assert property ($fell(filter_window)
        |-> (meas_pulse || $past(meas_pulse) || $past(meas_pulse, 2)) or (##[1:2] meas_pulse))
        else $error("filter window closed away from the measurement");
    c_meas: cover property (meas_pulse && !filter_window);
endmodule

bind occ_top occ_top_sva u_sva (
    .clock(clock),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .sensor_supply_vsel(sensor_supply_vsel),
    .meas_pulse(meas_pulse),
    .filter_window(filter_window)
);

// ==== bench/occ_load_model.sv ====
`timescale 1ns/1ps
module occ_load_model (
    // clock and count clear
    input wire clock,
    input wire clr,
    // actuator on the isolated contact
    input wire contact,
    output logic [15:0] rise_cnt,
    output logic [15:0] high_cnt
);
    logic last_r = 1'b0;
    // the actuator only sees edges and on-time, so that is all it keeps
    always @(posedge clock) begin
        last_r <= contact;
        if (clr) begin
            rise_cnt <= 16'h0000;
            high_cnt <= 16'h0000;
        end else begin
            if (contact === 1'b1 && last_r === 1'b0)
                rise_cnt <= rise_cnt + 16'h0001;
            if (contact === 1'b1)
                high_cnt <= high_cnt + 16'h0001;
        end
    end
endmodule

// ==== bench/output_channel_control_tb_top.sv ====
`timescale 1ns/1ps
module output_channel_control_tb_top;
    // short ms tick and slow clock rating keep rates and cycles within the run
    localparam MS = 2;
    localparam CHZ = 20000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [7:0] trig_active = 8'h00;
    logic burst_active = 1'b0;
    logic clr = 1'b1;
    logic [31:0] rd;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, switched_sensor_supply, switched_low_voltage_supply, contact, meas_pulse, filter_window;
    wire [1:0] vsel;
    wire [15:0] rise_cnt, high_cnt;
    wire [2:0] outs = {contact, switched_low_voltage_supply, switched_sensor_supply};
    integer errors = 0;
    integer n_compared = 0;
    integer seed = 4494;
    integer i, k, n, kon, kfl, onc;

    always #2 clock = ~clock;

    occ_top #(.NTRIG(8), .CLK_HZ(CHZ), .MS_TICKS(MS)) u_dut (
        .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trig_active(trig_active), .burst_active(burst_active),
        .switched_sensor_supply(switched_sensor_supply), .sensor_supply_vsel(vsel),
        .switched_low_voltage_supply(switched_low_voltage_supply), .contact(contact),
        .meas_pulse(meas_pulse), .filter_window(filter_window));
    occ_load_model u_load (.clock(clock), .clr(clr), .contact(contact), .rise_cnt(rise_cnt), .high_cnt(high_cnt));

    // ==========================================================
    // checking and closing
    task report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task near(input logic [31:0] got, input integer lo, input integer hi);
        n_compared = n_compared + 1;
        if ($isunknown(got) || got < lo || got > hi) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [31:0] exp_mode(input integer ch, input integer m);
        if ((m >= 4 && ch != 2) || (m == 3 && ch != 1))
            exp_mode = 32'h0;
        else
            exp_mode = m;
    endfunction

    // ==========================================================
    // bus and timing helpers, entered just after a rising edge
    task bus(input logic rw, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        integer t;
        t = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !rw;
        avs_write <= rw;
        do begin
            @(posedge clock);
            t = t + 1;
        end while (avs_waitrequest !== 1'b0 && t < 100);
        rd = avs_readdata;
        if (t >= 100)
            errors = errors + 1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task rdc(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rd, e);
    endtask
    task wait_cyc(input integer c);
        repeat (c) @(posedge clock);
    endtask
    task wait_meas;
        integer t;
        t = 0;
        do begin
            @(posedge clock);
            t = t + 1;
        end while (meas_pulse !== 1'b1 && t < 20000);
        if (t >= 20000)
            errors = errors + 1;
    endtask
    task scan;
        wait_meas;
        n = 0;
        kon = -1;
        kfl = -1;
        onc = 0;
        do begin
            @(posedge clock);
            n = n + 1;
            if (switched_sensor_supply === 1'b1)
                onc = onc + 1;
            if (kon < 0 && switched_sensor_supply === 1'b1)
                kon = n;
            if (kfl < 0 && filter_window === 1'b1)
                kfl = n;
        end while (meas_pulse !== 1'b1 && n < 10000);
    endtask
    task rate_run(input logic [31:0] rate, input integer win, input integer lo, input integer hi);
        wr(6'h18, rate);
        clr <= 1'b1;
        wait_cyc(200);
        clr <= 1'b0;
        wait_cyc(win);
        near(rise_cnt, lo, hi);
    endtask

    // ==========================================================
    // tests
    initial begin
        #400000;
        errors = errors + 1;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rdc(6'h00, 32'h0000003C);
        rdc(6'h18, 32'h00010000);
        for (i = 0; i < 3; i = i + 1)
            for (k = 0; k < 6; k = k + 1) begin
                wr(6'h0C + 6'(i * 4), k);
                rdc(6'h0C + 6'(i * 4), exp_mode(i, k));
            end
        wr(6'h1C, 32'h9);
        rdc(6'h1C, 32'h8);
        k = $random(seed);
        wr(6'h20, k);
        rdc(6'h20, k);
        wr(6'h3C, k);
        rdc(6'h3C, 32'h0);
        bus(1'b1, 6'h0C, 32'h200, 4'h3);
        wait_cyc(3);
        chk(vsel, 2'h2);
        bus(1'b1, 6'h0C, 32'h300, 4'h1);
        wr(6'h10, 32'h300);
        wait_cyc(3);
        chk(vsel, 2'h2);
        $display("register test done");
        for (i = 0; i < 12; i = i + 1) begin
            n = i / 3;
            wr(6'h0C + 6'(i % 3 * 4), {26'h0, n[1], n[0], 4'h2});
            wait_cyc(4);
            chk(outs[i % 3], n[1] ^ n[0]);
        end
        $display("digital test done");
        wr(6'h14, 32'h4);
        k = 16 + ($random(seed) & 31);
        rate_run({16'h0008, k[15:0]}, 2000, k * 8 / 10 - 1, k * 8 / 10 + 1);
        near(high_cnt, 998 - 10000 / (k * 8), 1002 + 10000 / (k * 8));
        rate_run({16'h0003, 16'h02BC}, 2000, 99, 101);
        wr(6'h14, 32'h5);
        rate_run({16'h000A, 16'h0028}, 30000, 7, 9);
        $display("rate test done");
        wr(6'h00, 32'h0);
        wr(6'h08, 32'h64);
        wr(6'h04, 32'h0);
        wr(6'h0C, 32'h1);
        wr(6'h00, 32'h2);
        burst_active <= 1'b1;
        scan;
        near(onc, 0, 0);
        burst_active <= 1'b0;
        wr(6'h04, 32'h1);
        scan;
        near(kon, 1994, 2006);
        near(onc, 1992, 2008);
        near(kfl, 3794, 3806);
        wait_cyc(100);
        burst_active <= 1'b1;
        wait_cyc(6);
        chk(switched_sensor_supply, 1'b1);
        burst_active <= 1'b0;
        $display("warm-up test done");
        wr(6'h14, 32'h22);
        for (i = 0; i < 3; i = i + 1) begin
            k = ($random(seed) & 8'hFE) | 1;
            n = (i == 0) ? 0 : (i == 1) ? ($random(seed) & 8'hFF) : 1;
            wr(6'h30, k);
            if (i == 0)
                chk(contact, 1'b1);
            trig_active <= n[7:0];
            wait_meas;
            wait_cyc(4);
            chk(contact, |(k[7:0] & n[7:0]));
        end
        $display("gating test done");
        report_and_stop;
    end
endmodule
